// ==== bapc_pkg.sv ====
// constants and types of the bus access permission checker
package bapc_pkg;
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
	} bapc_req_s;

	localparam int NSRC = 5;
	localparam int SRC_DBUS = 0;
	localparam int SRC_DMA = 1;
	localparam int NDMA = 3;
	localparam int SRC_PBUS = 4;
	localparam int N_UNRD_MAX = 4;
	localparam int UNRD_W = 18;

	// checked windows
	localparam logic [31:0] SRAM_BASE = 32'h3FFB_0000;
	localparam logic [31:0] SRAM_END = 32'h3FFF_FFFF;
	localparam logic [31:0] SRAM_BLK4_OFS = 32'h0000_8000;
	localparam logic [31:0] RTCF_BASE = 32'h3FF9_E000;
	localparam logic [31:0] RTCF_END = 32'h3FF9_FFFF;
	localparam logic [31:0] PB_BASE = 32'h3F40_0000;
	localparam logic [31:0] PB_END = 32'h3F4F_FFFF;
	localparam logic [31:0] PB_PERI_END = 32'h3F4B_FFFF;
	localparam logic [31:0] RTCS_BASE = 32'h3F42_1000;
	localparam logic [31:0] RTCS_END = 32'h3F42_2FFF;

	// field positions
	localparam int SRAM_HI_LSB = 27;
	localparam int SRAM_LO_LSB = 25;
	localparam int SRAM_SPLIT_LSB = 8;
	localparam int SRAM_SPLIT_W = 17;
	localparam int RTCF_HI_LSB = 13;
	localparam int RTCF_LO_LSB = 11;
	localparam int RTCF_SPLIT_LSB = 0;
	localparam int RTCF_SPLIT_W = 11;
	localparam int PB_VALID_LSB = 16;
	localparam int RTCS_HI_LSB = 14;
	localparam int RTCS_LO_LSB = 12;
	localparam int RTCS_SPLIT_LSB = 1;
	localparam int RTCS_SPLIT_W = 11;
	localparam int PB_PERI_EN_BIT = 0;

	// register byte offsets
	localparam logic [7:0] OFS_DSRAM = 8'h00;
	localparam logic [7:0] OFS_DRTC = 8'h04;
	localparam logic [7:0] OFS_DLOCK = 8'h08;
	localparam logic [7:0] OFS_DMA = 8'h0C;
	localparam logic [7:0] OFS_MLOCK = 8'h18;
	localparam logic [7:0] OFS_PBUS = 8'h1C;
	localparam logic [7:0] OFS_UNRD = 8'h20;
	localparam logic [7:0] OFS_PLOCK = 8'h30;
	localparam logic [7:0] OFS_IENA = 8'h34;
	localparam logic [7:0] OFS_ICLR = 8'h38;
	localparam logic [7:0] OFS_ISTAT = 8'h3C;
	localparam logic [7:0] OFS_CAP = 8'h40;

	// reset values: every region open, split at the base
	localparam logic [31:0] RST_DSRAM = 32'h1E00_00FF;
	localparam logic [31:0] RST_DRTC = 32'h0000_7800;
	localparam logic [31:0] RST_DMA = 32'h1E00_00FF;
	localparam logic [31:0] RST_PBUS = 32'h0000_F001;

	localparam int NFIFO = 15;
	localparam logic [NFIFO-1:0][31:0] FIFO_ADDR = {
		32'h6002_1000, 32'h6000_0000, 32'h6001_0000, 32'h6002_E000,
		32'h6000_F004, 32'h6002_D004, 32'h6001_6000, 32'h6001_6004,
		32'h6001_6008, 32'h6001_600C, 32'h6001_301C, 32'h6002_701C,
		32'h6008_0020, 32'h6008_1000, 32'h6009_0FFF
	};
endpackage : bapc_pkg

// ==== bapc_top.sv ====
// bus access permission checker: apb registers, checks, error capture
// Functional notes
// - data bus checks the sram window and the rtc fast window
// - after a bus lock is set, its permission registers ignore writes
// - a lock stays set until reset; software cannot clear it
// - data bus blocks 0 to 3 each have a write/read pair, bits 7:0
// - blocks 4 to 21 use pair 28:27 above split, 26:25 below
// - data bus sram split field is bits 24:8 relative to sram base
// - split address equals base plus field value times four
// - rtc fast pairs 14:13 above, 12:11 below, split field 10:0
// - deny any access whose type is not allowed for its region
// - denied accesses complete unstalled; writes dropped, reads invalid
// - data bus violation with enable captures address, type, size, interrupt
// - a held record is never overwritten by later violations
// - interrupt is a level until cleared; clearing drops the record
// - three dma paths checked separately, own registers and lock
// - dma permission registers share the data bus sram layout
// - dma violation captures address and type only, raises interrupt
// - peripheral bus covers its 1 MB window for reads and writes
// - bit 0 allows peripheral accesses up to the peripheral end
// - reads to fifteen fixed fifo addresses are always denied
// - four user 18-bit unreadable addresses, each with valid bit 16..19
// - rtc slow pairs 15:14 above, 13:12 below, split field 11:1
// - deny reads of active unreadable addresses; capture and interrupt
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module bapc_top #(
	parameter int N_UNRD = 4
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire bapc_pkg::bapc_req_s i_dbus_req,
	input wire bapc_pkg::bapc_req_s [bapc_pkg::NDMA-1:0] i_dma_req,
	input wire bapc_pkg::bapc_req_s i_pbus_req,
	output logic [bapc_pkg::NSRC-1:0] o_deny,
	output logic [bapc_pkg::NSRC-1:0] o_irq
);
	if (N_UNRD < 1 || N_UNRD > bapc_pkg::N_UNRD_MAX)
	begin : g_bad_n_unrd
		$error("N_UNRD must lie between 1 and 4");
	end

	logic [31:0] dsram_q;
	logic [31:0] drtc_q;
	logic dlock_q;
	logic [bapc_pkg::NDMA-1:0][31:0] dma_q;
	logic [bapc_pkg::NDMA-1:0] mlock_q;
	logic [31:0] pbus_q;
	logic [N_UNRD-1:0][bapc_pkg::UNRD_W-1:0] unrd_q;
	logic plock_q;
	logic [bapc_pkg::NSRC-1:0] ena_q;
	logic [bapc_pkg::NSRC-1:0] err_q;
	logic [bapc_pkg::NSRC-1:0][31:0] cap_addr_q;
	logic [bapc_pkg::NSRC-1:0] cap_wr_q;
	logic [bapc_pkg::NSRC-1:0][1:0] cap_size_q;
	logic [bapc_pkg::NSRC-1:0] deny_q;
	logic [bapc_pkg::NSRC-1:0] deny_c;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_c;
	logic hit_c;
	logic setup;
	logic wr_go;
	bapc_pkg::bapc_req_s [bapc_pkg::NSRC-1:0] req;

	assign setup = i_psel & ~i_penable;
	assign wr_go = i_psel & i_penable & pready_q & i_pwrite;
	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_deny = deny_q;
	assign o_irq = err_q;

	assign req[bapc_pkg::SRC_DBUS] = i_dbus_req;
	assign req[bapc_pkg::SRC_PBUS] = i_pbus_req;
	assign req[bapc_pkg::SRC_DMA+bapc_pkg::NDMA-1:bapc_pkg::SRC_DMA] = i_dma_req;

	function automatic logic pair_ok(input logic [1:0] p, input logic wr);
		// upper bit grants write, lower bit grants read
		return wr ? p[1] : p[0];
	endfunction : pair_ok

	function automatic logic split_ok(
		input logic [31:0] addr,
		input logic [31:0] base,
		input logic [31:0] fld,
		input logic [1:0] hi,
		input logic [1:0] lo,
		input logic wr
	);
		logic [31:0] split;
		split = base + (fld << 2);
		return (addr >= split) ? pair_ok(hi, wr) : pair_ok(lo, wr);
	endfunction : split_ok

	function automatic logic sram_ok(
		input logic [31:0] perm,
		input bapc_pkg::bapc_req_s r
	);
		logic [31:0] ofs;
		logic [31:0] fld;
		ofs = r.addr - bapc_pkg::SRAM_BASE;
		fld = 32'(perm[bapc_pkg::SRAM_SPLIT_LSB +: bapc_pkg::SRAM_SPLIT_W]);
		if (ofs < bapc_pkg::SRAM_BLK4_OFS)
		begin
			return pair_ok(perm[{ofs[14:13], 1'b0} +: 2], r.write);
		end
		return split_ok(r.addr, bapc_pkg::SRAM_BASE, fld,
			perm[bapc_pkg::SRAM_HI_LSB +: 2],
			perm[bapc_pkg::SRAM_LO_LSB +: 2], r.write);
	endfunction : sram_ok

	function automatic logic in_win(
		input logic [31:0] a,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		return (a >= lo) && (a <= hi);
	endfunction : in_win

	always_comb
	begin
		logic fifo_hit;
		logic [31:0] pa;
		deny_c = '0;
		fifo_hit = 1'b0;
		pa = req[bapc_pkg::SRC_PBUS].addr;
		if (in_win(req[bapc_pkg::SRC_DBUS].addr, bapc_pkg::SRAM_BASE,
			bapc_pkg::SRAM_END))
		begin
			deny_c[bapc_pkg::SRC_DBUS] = !sram_ok(dsram_q, req[bapc_pkg::SRC_DBUS]);
		end
		else if (in_win(req[bapc_pkg::SRC_DBUS].addr, bapc_pkg::RTCF_BASE,
			bapc_pkg::RTCF_END))
		begin
			deny_c[bapc_pkg::SRC_DBUS] = !split_ok(req[bapc_pkg::SRC_DBUS].addr,
				bapc_pkg::RTCF_BASE,
				32'(drtc_q[bapc_pkg::RTCF_SPLIT_LSB +: bapc_pkg::RTCF_SPLIT_W]),
				drtc_q[bapc_pkg::RTCF_HI_LSB +: 2],
				drtc_q[bapc_pkg::RTCF_LO_LSB +: 2],
				req[bapc_pkg::SRC_DBUS].write);
		end
		// each dma path on its own register
		for (int i = 0; i < bapc_pkg::NDMA; i++)
		begin
			if (in_win(req[bapc_pkg::SRC_DMA+i].addr, bapc_pkg::SRAM_BASE,
				bapc_pkg::SRAM_END))
			begin
				deny_c[bapc_pkg::SRC_DMA+i] = !sram_ok(dma_q[i], req[bapc_pkg::SRC_DMA+i]);
			end
		end
		// fixed fifo words, matched on the word offset
		for (int k = 0; k < bapc_pkg::NFIFO; k++)
		begin
			if (pa[19:2] == bapc_pkg::FIFO_ADDR[k][19:2])
			begin
				fifo_hit = 1'b1;
			end
		end
		// user unreadable words gated by their valid bit
		for (int k = 0; k < N_UNRD; k++)
		begin
			if (pbus_q[bapc_pkg::PB_VALID_LSB+k] && (pa[19:2] == unrd_q[k]))
			begin
				fifo_hit = 1'b1;
			end
		end
		if (in_win(pa, bapc_pkg::PB_BASE, bapc_pkg::PB_END))
		begin
			if (in_win(pa, bapc_pkg::RTCS_BASE, bapc_pkg::RTCS_END))
			begin
				deny_c[bapc_pkg::SRC_PBUS] = !split_ok(pa, bapc_pkg::RTCS_BASE,
					32'(pbus_q[bapc_pkg::RTCS_SPLIT_LSB +: bapc_pkg::RTCS_SPLIT_W]),
					pbus_q[bapc_pkg::RTCS_HI_LSB +: 2],
					pbus_q[bapc_pkg::RTCS_LO_LSB +: 2],
					req[bapc_pkg::SRC_PBUS].write);
			end
			else if (pa <= bapc_pkg::PB_PERI_END)
			begin
				deny_c[bapc_pkg::SRC_PBUS] = !pbus_q[bapc_pkg::PB_PERI_EN_BIT];
			end
			if (!req[bapc_pkg::SRC_PBUS].write && fifo_hit)
			begin
				deny_c[bapc_pkg::SRC_PBUS] = 1'b1;
			end
		end
		for (int s = 0; s < bapc_pkg::NSRC; s++)
		begin
			deny_c[s] = deny_c[s] & req[s].valid;
		end
	end

	// denial is a one-cycle verdict, the requester is never held
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			deny_q <= '0;
		end
		else if (i_ce)
		begin
			deny_q <= deny_c;
		end
	end

	// zero-wait apb: ready one cycle after setup
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end
		else if (i_ce)
		begin
			pready_q <= setup;
			prdata_q <= (setup && !i_pwrite) ? rd_c : '0;
			pslverr_q <= setup & ~hit_c;
		end
	end

	always_comb
	begin
		rd_c = '0;
		hit_c = 1'b1;
		case (i_paddr)
			bapc_pkg::OFS_DSRAM: rd_c = dsram_q;
			bapc_pkg::OFS_DRTC: rd_c = drtc_q;
			bapc_pkg::OFS_DLOCK: rd_c = 32'(dlock_q);
			bapc_pkg::OFS_MLOCK: rd_c = 32'(mlock_q);
			bapc_pkg::OFS_PBUS: rd_c = pbus_q;
			bapc_pkg::OFS_PLOCK: rd_c = 32'(plock_q);
			bapc_pkg::OFS_IENA: rd_c = 32'(ena_q);
			bapc_pkg::OFS_ICLR: rd_c = '0;
			bapc_pkg::OFS_ISTAT: rd_c = 32'(err_q);
			default:
			begin
				hit_c = 1'b0;
				for (int i = 0; i < bapc_pkg::NDMA; i++)
				begin
					if (i_paddr == bapc_pkg::OFS_DMA + 8'(4 * i))
					begin
						rd_c = dma_q[i];
						hit_c = 1'b1;
					end
				end
				for (int i = 0; i < N_UNRD; i++)
				begin
					if (i_paddr == bapc_pkg::OFS_UNRD + 8'(4 * i))
					begin
						rd_c = 32'(unrd_q[i]);
						hit_c = 1'b1;
					end
				end
				for (int s = 0; s < bapc_pkg::NSRC; s++)
				begin
					if (i_paddr == bapc_pkg::OFS_CAP + 8'(8 * s))
					begin
						rd_c = cap_addr_q[s];
						hit_c = 1'b1;
					end
					if (i_paddr == bapc_pkg::OFS_CAP + 8'(8 * s + 4))
					begin
						rd_c = 32'({cap_size_q[s], cap_wr_q[s]});
						hit_c = 1'b1;
					end
				end
			end
		endcase
	end

	// data bus configuration
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			dsram_q <= bapc_pkg::RST_DSRAM;
			drtc_q <= bapc_pkg::RST_DRTC;
			dlock_q <= 1'b0;
		end
		else if (i_ce)
		begin
			// data bus registers frozen by lock
			if (wr_go && i_paddr == bapc_pkg::OFS_DSRAM && !dlock_q)
			begin
				dsram_q <= i_pwdata;
			end
			if (wr_go && i_paddr == bapc_pkg::OFS_DRTC && !dlock_q)
			begin
				drtc_q <= i_pwdata;
			end
			if (wr_go && i_paddr == bapc_pkg::OFS_DLOCK && i_pwdata[0])
			begin
				dlock_q <= 1'b1;
			end
		end
	end

	for (genvar i = 0; i < bapc_pkg::NDMA; i++)
	begin : g_dma
		always_ff @(posedge i_clk or negedge i_rstn)
		begin
			if (!i_rstn)
			begin
				dma_q[i] <= bapc_pkg::RST_DMA;
				mlock_q[i] <= 1'b0;
			end
			else if (i_ce)
			begin
				if (wr_go && i_paddr == bapc_pkg::OFS_DMA + 8'(4 * i) && !mlock_q[i])
				begin
					dma_q[i] <= i_pwdata;
				end
				if (wr_go && i_paddr == bapc_pkg::OFS_MLOCK && i_pwdata[i])
				begin
					mlock_q[i] <= 1'b1;
				end
			end
		end
	end

	// peripheral bus configuration
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pbus_q <= bapc_pkg::RST_PBUS;
			plock_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (wr_go && i_paddr == bapc_pkg::OFS_PBUS && !plock_q)
			begin
				pbus_q <= i_pwdata;
			end
			if (wr_go && i_paddr == bapc_pkg::OFS_PLOCK && i_pwdata[0])
			begin
				plock_q <= 1'b1;
			end
		end
	end

	for (genvar i = 0; i < N_UNRD; i++)
	begin : g_unrd
		always_ff @(posedge i_clk or negedge i_rstn)
		begin
			if (!i_rstn)
			begin
				unrd_q[i] <= '0;
			end
			else if (i_ce)
			begin
				// unreadable words share the peripheral lock
				if (wr_go && i_paddr == bapc_pkg::OFS_UNRD + 8'(4 * i) && !plock_q)
				begin
					unrd_q[i] <= i_pwdata[bapc_pkg::UNRD_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ena_q <= '0;
		end
		else if (i_ce)
		begin
			if (wr_go && i_paddr == bapc_pkg::OFS_IENA)
			begin
				ena_q <= i_pwdata[bapc_pkg::NSRC-1:0];
			end
		end
	end

	for (genvar s = 0; s < bapc_pkg::NSRC; s++)
	begin : g_cap
		logic clr;
		logic take;
		assign clr = wr_go && (i_paddr == bapc_pkg::OFS_ICLR) && i_pwdata[s];
		// only a free record, or one cleared now, takes a new error
		assign take = deny_c[s] & ena_q[s] & (~err_q[s] | clr);
		always_ff @(posedge i_clk or negedge i_rstn)
		begin
			if (!i_rstn)
			begin
				err_q[s] <= 1'b0;
				cap_addr_q[s] <= '0;
				cap_wr_q[s] <= 1'b0;
				cap_size_q[s] <= '0;
			end
			else if (i_ce)
			begin
				// level flag; a new error beats the clear
				err_q[s] <= take | (err_q[s] & ~clr);
				if (take)
				begin
					// capture, size only off the dma paths
					cap_addr_q[s] <= req[s].addr;
					cap_wr_q[s] <= req[s].write;
					cap_size_q[s] <= (s >= bapc_pkg::SRC_DMA && s < bapc_pkg::SRC_PBUS)
						? 2'h0 : req[s].size;
				end
				else if (clr)
				begin
					cap_addr_q[s] <= '0;
					cap_wr_q[s] <= 1'b0;
					cap_size_q[s] <= '0;
				end
			end
		end
	end
endmodule : bapc_top

`default_nettype wire

// ==== bapc_master.sv ====
// request launcher standing in for the cpu, dma and peripheral masters
`timescale 1ns/1ns
`default_nettype none
module bapc_master (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_go,
	input wire logic [2:0] i_src,
	input wire bapc_pkg::bapc_req_s i_cmd,
	output var bapc_pkg::bapc_req_s o_dbus,
	output var bapc_pkg::bapc_req_s [bapc_pkg::NDMA-1:0] o_dma,
	output var bapc_pkg::bapc_req_s o_pbus
);
	bapc_pkg::bapc_req_s idle;
	// released lines carry the inverse, so a stale request never looks valid
	assign idle = {1'b0, ~i_cmd[34:0]};
	// one-cycle requests: a master never waits for a permission answer
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_dbus <= '0;
			o_dma <= '0;
			o_pbus <= '0;
		end
		else
		begin
			o_dbus <= (i_go && i_src == 3'h0) ? i_cmd : idle;
			for (int k = 0; k < 3; k++)
				o_dma[k] <= (i_go && i_src == 3'(k + 1)) ? i_cmd : idle;
			o_pbus <= (i_go && i_src == 3'h4) ? i_cmd : idle;
		end
	end
endmodule : bapc_master
`default_nettype wire

// ==== bapc_chk.sv ====
// port assertions of the permission checker
`timescale 1ns/1ns
`default_nettype none
module bapc_chk #(
	parameter int N_UNRD = 4
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire bapc_pkg::bapc_req_s i_dbus_req,
	input wire bapc_pkg::bapc_req_s [bapc_pkg::NDMA-1:0] i_dma_req,
	input wire bapc_pkg::bapc_req_s i_pbus_req,
	input wire logic [bapc_pkg::NSRC-1:0] o_deny,
	input wire logic [bapc_pkg::NSRC-1:0] o_irq
);
	logic clr_hit;
	logic in_win;
	assign clr_hit = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h38;
	assign in_win = i_dbus_req.addr >= bapc_pkg::RTCF_BASE && i_dbus_req.addr <= bapc_pkg::SRAM_END;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	property p_ready;
		i_psel && !i_penable && i_ce |=> o_pready ##1 !o_pready;
	endproperty
	a_ready: assert property (p_ready) else $error("apb answer late or long");
	property p_rdata;
		!o_pready |-> o_prdata == 32'h0000_0000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside access");
	property p_open;
		i_dbus_req.valid && !in_win |=> !o_deny[0];
	endproperty
	a_open: assert property (p_open) else $error("unchecked address denied");
	property p_fifo;
		i_pbus_req.valid && !i_pbus_req.write && i_pbus_req.addr == 32'h3F41_6004 |=> o_deny[4];
	endproperty
	a_fifo: assert property (p_fifo) else $error("fixed fifo read passed");
	property p_cause;
		o_deny[0] |-> $past(i_dbus_req.valid);
	endproperty
	a_cause: assert property (p_cause) else $error("deny without request");
	property p_rise;
		$rose(o_irq[0]) |-> o_deny[0];
	endproperty
	a_rise: assert property (p_rise) else $error("irq without denial");
	property p_hold;
		o_irq[0] && !clr_hit |=> o_irq[0];
	endproperty
	a_hold: assert property (p_hold) else $error("irq dropped uncleared");
	property p_clear;
		clr_hit && i_pwdata[0] && !i_dbus_req.valid |=> !o_irq[0];
	endproperty
	a_clear: assert property (p_clear) else $error("irq not cleared");
endmodule : bapc_chk
bind bapc_top bapc_chk #(.N_UNRD(N_UNRD)) chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_dbus_req(i_dbus_req), .i_dma_req(i_dma_req), .i_pbus_req(i_pbus_req),
	.o_deny(o_deny), .o_irq(o_irq));
`default_nettype wire

// ==== bapc_top_test.sv ====
// self-checking testbench of the permission checker
`timescale 1ns/1ns
`default_nettype none
`define CK(w, e, a) \
	begin \
		comparisons++; \
		if ((a) !== (e)) \
		begin \
			$display("unexpected %s: expected %h seen %h", w, e, a); \
			bad_count++; \
		end \
	end
module bapc_top_test;
	localparam logic [31:0] SB = bapc_pkg::SRAM_BASE;
	localparam logic [31:0] RB = bapc_pkg::RTCF_BASE;
	localparam logic [31:0] RS = bapc_pkg::RTCS_BASE;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = '0;
	logic [31:0] pwd = '0;
	logic [31:0] prd;
	logic prdy;
	logic perr;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [2:0] src = '0;
	bapc_pkg::bapc_req_s cmd = '0;
	bapc_pkg::bapc_req_s dbus;
	bapc_pkg::bapc_req_s pbus;
	bapc_pkg::bapc_req_s [bapc_pkg::NDMA-1:0] dma;
	logic [bapc_pkg::NSRC-1:0] deny;
	logic [bapc_pkg::NSRC-1:0] irq;
	logic [31:0] rd;
	logic er;
	int bad_count = 0;
	int comparisons = 0;
	always #2 i_clk = ~i_clk;
	bapc_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .i_dbus_req(dbus), .i_dma_req(dma),
		.i_pbus_req(pbus), .o_deny(deny), .o_irq(irq));
	bapc_master mst_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_src(src),
		.i_cmd(cmd), .o_dbus(dbus), .o_dma(dma), .o_pbus(pbus));
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (prdy !== 1'b1 && n < 8);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1)
		begin
			bad_count++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CK("register", e, rd)
	endtask : rck
	task automatic acc(input logic [2:0] s, input logic w, input logic [31:0] a, input logic e);
		@(posedge i_clk);
		go <= 1'b1;
		src <= s;
		cmd <= '{1'b1, w, 2'h2, a};
		@(posedge i_clk);
		go <= 1'b0;
		@(posedge i_clk);
		@(negedge i_clk);
		`CK("deny", e, deny[s])
	endtask : acc
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		rck(8'h00, 32'h1E00_00FF);
		rck(8'h04, 32'h0000_7800);
		rck(8'h10, 32'h1E00_00FF);
		rck(8'h1C, 32'h0000_F001);
		rck(8'h3C, 32'h0000_0000);
		rck(8'hFC, 32'h0000_0000);
		`CK("slverr", 1'b1, er)
		$display("test reset done");
		wr(8'h34, 32'h0000_001F);
		wr(8'h00, 32'h1E00_00F7);
		acc(3'h0, 1'b1, SB + 32'h0000_2000, 1'b1);
		acc(3'h0, 1'b0, SB + 32'h0000_2004, 1'b0);
		acc(3'h0, 1'b1, SB + 32'h0000_6000, 1'b0);
		acc(3'h0, 1'b1, 32'h3F00_0000, 1'b0);
		rck(8'h40, SB + 32'h0000_2000);
		rck(8'h44, 32'h0000_0005);
		rck(8'h3C, 32'h0000_0001);
		`CK("irq", 5'h01, irq)
		// split lands in block 18, clear of blocks 0 to 5
		wr(8'h00, 32'h1700_00FF);
		acc(3'h0, 1'b0, SB + 32'h0004_0000, 1'b1);
		acc(3'h0, 1'b0, SB + 32'h0003_FFFC, 1'b0);
		acc(3'h0, 1'b1, SB + 32'h0004_0000, 1'b0);
		wr(8'h04, 32'h0000_3900);
		acc(3'h0, 1'b1, RB + 32'h0000_0400, 1'b1);
		acc(3'h0, 1'b1, RB + 32'h0000_03FC, 1'b0);
		acc(3'h0, 1'b0, RB + 32'h0000_0400, 1'b0);
		rck(8'h40, SB + 32'h0000_2000);
		wr(8'h38, 32'h0000_0001);
		rck(8'h3C, 32'h0000_0000);
		`CK("irq", 5'h00, irq)
		rck(8'h40, 32'h0000_0000);
		$display("test data bus done");
		wr(8'h08, 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		rck(8'h00, 32'h1700_00FF);
		wr(8'h08, 32'h0000_0000);
		rck(8'h08, 32'h0000_0001);
		acc(3'h0, 1'b0, SB + 32'h0004_0000, 1'b1);
		// a frozen block must not register a denial
		@(posedge i_clk);
		ce <= 1'b0;
		acc(3'h0, 1'b0, SB + 32'h0004_0000, 1'b0);
		@(posedge i_clk);
		ce <= 1'b1;
		$display("test lock done");
		wr(8'h10, 32'h1E00_00FC);
		acc(3'h2, 1'b1, SB, 1'b1);
		acc(3'h1, 1'b1, SB, 1'b0);
		acc(3'h3, 1'b1, SB, 1'b0);
		rck(8'h50, SB);
		rck(8'h54, 32'h0000_0001);
		wr(8'h18, 32'h0000_0002);
		wr(8'h10, 32'h1E00_00FF);
		rck(8'h10, 32'h1E00_00FC);
		wr(8'h0C, 32'h1E00_00FC);
		rck(8'h0C, 32'h1E00_00FC);
		$display("test dma done");
		wr(8'h20, 32'h0000_C010);
		wr(8'h1C, 32'h0001_3020);
		acc(3'h4, 1'b0, 32'h3F40_1000, 1'b1);
		acc(3'h4, 1'b0, 32'h3F4C_0000, 1'b0);
		acc(3'h4, 1'b0, RS + 32'h0000_0040, 1'b1);
		acc(3'h4, 1'b0, RS + 32'h0000_003C, 1'b0);
		// open the peripheral switch so outside the rtc slow window only the fifo and unreadable words deny
		wr(8'h1C, 32'h0001_3021);
		// fifo words are matched on their offset inside the peripheral window
		acc(3'h4, 1'b0, 32'h3F41_6004, 1'b1);
		acc(3'h4, 1'b1, 32'h3F41_6004, 1'b0);
		acc(3'h4, 1'b0, 32'h3F43_0040, 1'b1);
		acc(3'h4, 1'b0, 32'h3F43_0044, 1'b0);
		rck(8'h60, 32'h3F40_1000);
		rck(8'h64, 32'h0000_0004);
		$display("test peripheral bus done");
		@(posedge i_clk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		rck(8'h08, 32'h0000_0000);
		rck(8'h00, 32'h1E00_00FF);
		$display("test second reset done");
		final_report();
	end
endmodule : bapc_top_test
`default_nettype wire
